// *** rtl/bcme_regs.svh ***
`ifndef BCME_REGS_SVH
`define BCME_REGS_SVH

// Reset values
`define BCME_RST_PC        16'h0000
`define BCME_RST_SP        8'h07
`define BCME_RST_BYTE      8'h00
`define BCME_RST_LATCH     8'hFF

// Special register direct addresses
`define BCME_SFR_P0        8'h80
`define BCME_SFR_SP        8'h81
`define BCME_SFR_DPL       8'h82
`define BCME_SFR_DPH       8'h83
`define BCME_SFR_P1        8'h90
`define BCME_SFR_P2        8'hA0
`define BCME_SFR_P3        8'hB0
`define BCME_SFR_PSW       8'hD0
`define BCME_SFR_ACC       8'hE0
`define BCME_SFR_B         8'hF0

// Field positions
`define BCME_PSW_CY        7
`define BCME_PSW_BANK_HI   4
`define BCME_PSW_BANK_LO   3
`define BCME_BITRAM_BASE   4'h2

// Whole-byte opcodes
`define BCME_OP_IND_JUMP   8'h73
`define BCME_OP_JBIT_CLR   8'h30
`define BCME_OP_JCY_CLR    8'h50
`define BCME_OP_JACC_NZ    8'h70
`define BCME_OP_JACC_Z     8'h60
`define BCME_OP_LONG_CALL  8'h12
`define BCME_OP_LONG_JUMP  8'h02
`define BCME_OP_MV_A_DIR   8'hE5
`define BCME_OP_MV_A_IMM   8'h74
`define BCME_OP_MV_DIR_A   8'hF5
`define BCME_OP_MV_DIR_DIR 8'h85
`define BCME_OP_MV_DIR_IMM 8'h75

// Register-form opcode groups, upper five bits
`define BCME_GR_A_RN       5'h1D
`define BCME_GR_RN_A       5'h1F
`define BCME_GR_RN_DIR     5'h15
`define BCME_GR_RN_IMM     5'h0F
`define BCME_GR_DIR_RN     5'h11

// Indirect-form opcode groups, upper seven bits
`define BCME_GI_A_RI       7'h73
`define BCME_GI_RI_A       7'h7B
`define BCME_GI_DIR_RI     7'h43
`define BCME_GI_RI_DIR     7'h53
`define BCME_GI_RI_IMM     7'h3B

`endif

// *** rtl/bcme_pkg.sv ***
package bcme_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    S_WAIT,
    S_GRAB,
    S_EXEC,
    S_PUSH_LO,
    S_PUSH_HI
  } bcme_state_t;

  // Four port bytes travel together
  typedef struct packed {
    logic [7:0] p3;
    logic [7:0] p2;
    logic [7:0] p1;
    logic [7:0] p0;
  } bcme_port_t;

  // One byte write request from the executing move
  typedef struct packed {
    logic       en;
    logic       raw;
    logic [7:0] addr;
    logic [7:0] data;
  } bcme_wr_t;

endpackage : bcme_pkg

// *** rtl/bcme_addr_add.sv ***
`timescale 1ns/1ps
`default_nettype none
module bcme_addr_add #(
  parameter int W = 16
) (
  // Operands
  input  wire logic [W-1:0] i_base,
  input  wire logic [7:0]   i_off,
  input  wire logic         i_signed,
  // Result
  output logic [W-1:0]      o_sum
);

  // Narrower widths cannot hold a sign-extended byte
  if (W < 8) begin : g_bad_w
    $error("bcme_addr_add: W must be at least 8");
  end

  logic [W-1:0] ext;  // Offset widened to full width

  // Sign or zero extension, then a full-width wrapping add
  always_comb begin
    ext   = {{(W-8){i_signed & i_off[7]}}, i_off};
    o_sum = i_base + ext;
  end

endmodule : bcme_addr_add
`default_nettype wire

// *** rtl/bcme_core.sv ***
// Functional notes
// - Indirect jump loads zero-extended accumulator plus pointer
// - Indirect jump sum wraps modulo 65536
// - Indirect jump keeps accumulator, pointer, flags
// - Bit-clear branch: pc+3, branch on zero
// - Third byte is signed displacement
// - Carry-clear branch: pc+2, carry untouched
// - Opcode 70: branch when accumulator nonzero
// - Opcode 60: branch when accumulator zero
// - Long call pushes pc+3, low first
// - Stack pointer pre-increments, ends two higher
// - Long call loads high then low target
// - Call and jump reach full 64K
// - Long jump opcode 02, no push
// - Byte move copies, fifteen modes, flags kept unless PSW is the destination
// - Port bit tests read output latch
`timescale 1ns/1ps
`default_nettype none
`include "bcme_regs.svh"
module bcme_core
  import bcme_pkg::*;
#(
  parameter int IRAM_DEPTH = 256
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // Program memory, data one cycle after address
  output logic [15:0]      o_pmem_addr,
  input  wire logic [7:0]  i_pmem_data,
  // Port pins and output latches
  input  wire bcme_port_t  i_port_pins,
  output var bcme_port_t   o_port_latch,
  // Core state view
  output logic [7:0]       o_acc,
  output logic [7:0]       o_sp,
  output logic [15:0]      o_data_pointer,
  output logic [7:0]       o_psw,
  output logic             o_instr_done
);

  // Byte addressing of internal RAM needs all 256 entries
  if (IRAM_DEPTH != 256) begin : g_bad_depth
    $error("bcme_core: IRAM_DEPTH must be 256");
  end

  bcme_state_t state_q;                     // Sequencer state
  logic [1:0]  idx_q;                       // Instruction byte index
  logic [1:0]  len_q;                       // Instruction length
  logic [7:0]  op_q, b1_q, b2_q;            // Instruction bytes
  logic [15:0] pc_q;                        // Program counter
  logic [7:0]  acc_q, b_q, sp_q, psw_q;     // Core registers
  logic [7:0]  dpl_q, dph_q;                // Data pointer halves
  bcme_port_t  latch_q;                     // Port output latches
  logic        done_q;                      // Instruction retired
  logic [7:0]  ram [0:IRAM_DEPTH-1];        // Internal data RAM

  // Combinational execution terms
  bcme_wr_t    wr;                          // Move write request
  logic [7:0]  rn_addr, ri_addr, bit_addr;  // Operand addresses
  logic        bit_val, take;               // Branch decision terms
  logic [7:0]  bit_byte;                    // Byte holding the tested bit
  logic [7:0]  br_off;                      // Displacement to add
  logic [15:0] br_base, br_tgt;             // Adder operands and sum
  logic        is_ind, exec;                // Decode helpers

  // Instruction length from the opcode byte
  function automatic logic [1:0] ilen(input logic [7:0] op);
    logic [1:0] n;
    n = 2'd1;
    case (op)
      `BCME_OP_JBIT_CLR, `BCME_OP_LONG_CALL, `BCME_OP_LONG_JUMP,
      `BCME_OP_MV_DIR_DIR, `BCME_OP_MV_DIR_IMM: n = 2'd3;
      `BCME_OP_JCY_CLR, `BCME_OP_JACC_NZ, `BCME_OP_JACC_Z,
      `BCME_OP_MV_A_DIR, `BCME_OP_MV_A_IMM, `BCME_OP_MV_DIR_A: n = 2'd2;
      default: begin
        if (op[7:3] == `BCME_GR_RN_DIR || op[7:3] == `BCME_GR_RN_IMM ||
            op[7:3] == `BCME_GR_DIR_RN || op[7:1] == `BCME_GI_DIR_RI ||
            op[7:1] == `BCME_GI_RI_DIR || op[7:1] == `BCME_GI_RI_IMM) begin
          n = 2'd2;
        end
      end
    endcase
    return n;
  endfunction : ilen

  // Direct-address read; lat picks latch over pin for ports
  function automatic logic [7:0] dir_rd(input logic [7:0] a, input logic lat);
    logic [7:0] v;
    v = 8'h00;
    if (!a[7]) begin
      v = ram[a];
    end else begin
      case (a)
        `BCME_SFR_ACC: v = acc_q;
        `BCME_SFR_B:   v = b_q;
        `BCME_SFR_SP:  v = sp_q;
        `BCME_SFR_DPL: v = dpl_q;
        `BCME_SFR_DPH: v = dph_q;
        `BCME_SFR_PSW: v = psw_q;
        `BCME_SFR_P0:  v = lat ? latch_q.p0 : i_port_pins.p0;
        `BCME_SFR_P1:  v = lat ? latch_q.p1 : i_port_pins.p1;
        `BCME_SFR_P2:  v = lat ? latch_q.p2 : i_port_pins.p2;
        `BCME_SFR_P3:  v = lat ? latch_q.p3 : i_port_pins.p3;
        default:       v = 8'h00;       // Unimplemented reads as zero
      endcase
    end
    return v;
  endfunction : dir_rd

  // Operand addressing and branch decision
  always_comb begin
    exec     = (state_q == S_EXEC);
    rn_addr  = {3'b000, psw_q[`BCME_PSW_BANK_HI:`BCME_PSW_BANK_LO], op_q[2:0]};
    ri_addr  = ram[{3'b000, psw_q[`BCME_PSW_BANK_HI:`BCME_PSW_BANK_LO], 2'b00, op_q[0]}];
    // Bits below 80 live in RAM 20..2F, others in registers
    bit_addr = b1_q[7] ? {b1_q[7:3], 3'b000} : {`BCME_BITRAM_BASE, b1_q[6:3]};
    bit_byte = dir_rd(bit_addr, 1'b1);
    bit_val  = bit_byte[b1_q[2:0]];
    is_ind   = (op_q == `BCME_OP_IND_JUMP);
    br_base  = is_ind ? {dph_q, dpl_q} : pc_q;
    br_off   = is_ind ? acc_q : ((op_q == `BCME_OP_JBIT_CLR) ? b2_q : b1_q);
    case (op_q)
      `BCME_OP_IND_JUMP: take = 1'b1;
      `BCME_OP_JBIT_CLR: take = !bit_val;
      `BCME_OP_JCY_CLR:  take = !psw_q[`BCME_PSW_CY];
      `BCME_OP_JACC_NZ:  take = |acc_q;
      `BCME_OP_JACC_Z:   take = ~|acc_q;
      default:           take = 1'b0;
    endcase
  end

  // Relative and indirect targets share one wrapping adder
  bcme_addr_add #(.W(16)) u_add (
    .i_base   (br_base),
    .i_off    (br_off),
    .i_signed (!is_ind),
    .o_sum    (br_tgt)
  );

  // Byte move decode: source read, destination request
  always_comb begin
    wr = '0;
    if (op_q[7:3] == `BCME_GR_A_RN) begin
      wr = {1'b1, 1'b0, `BCME_SFR_ACC, ram[rn_addr]};
    end else if (op_q[7:3] == `BCME_GR_RN_A) begin
      wr = {1'b1, 1'b0, rn_addr, acc_q};
    end else if (op_q[7:3] == `BCME_GR_RN_DIR) begin
      wr = {1'b1, 1'b0, rn_addr, dir_rd(b1_q, 1'b0)};
    end else if (op_q[7:3] == `BCME_GR_RN_IMM) begin
      wr = {1'b1, 1'b0, rn_addr, b1_q};
    end else if (op_q[7:3] == `BCME_GR_DIR_RN) begin
      wr = {1'b1, 1'b0, b1_q, ram[rn_addr]};
    end else if (op_q[7:1] == `BCME_GI_A_RI) begin
      wr = {1'b1, 1'b0, `BCME_SFR_ACC, ram[ri_addr]};
    end else if (op_q[7:1] == `BCME_GI_RI_A) begin
      wr = {1'b1, 1'b1, ri_addr, acc_q};
    end else if (op_q[7:1] == `BCME_GI_DIR_RI) begin
      wr = {1'b1, 1'b0, b1_q, ram[ri_addr]};
    end else if (op_q[7:1] == `BCME_GI_RI_DIR) begin
      wr = {1'b1, 1'b1, ri_addr, dir_rd(b1_q, 1'b0)};
    end else if (op_q[7:1] == `BCME_GI_RI_IMM) begin
      wr = {1'b1, 1'b1, ri_addr, b1_q};
    end else begin
      case (op_q)
        `BCME_OP_MV_A_DIR:   wr = {1'b1, 1'b0, `BCME_SFR_ACC, dir_rd(b1_q, 1'b0)};
        `BCME_OP_MV_A_IMM:   wr = {1'b1, 1'b0, `BCME_SFR_ACC, b1_q};
        `BCME_OP_MV_DIR_A:   wr = {1'b1, 1'b0, b1_q, acc_q};
        // Source byte comes first, destination second
        `BCME_OP_MV_DIR_DIR: wr = {1'b1, 1'b0, b2_q, dir_rd(b1_q, 1'b0)};
        `BCME_OP_MV_DIR_IMM: wr = {1'b1, 1'b0, b1_q, b2_q};
        default:             wr = '0;               // Not a move
      endcase
    end
    wr.en = wr.en & exec;
  end

  // Fetch sequencer; every byte waits one cycle for memory
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_q <= S_WAIT;
      idx_q   <= 2'd0;
      len_q   <= 2'd1;
      done_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        S_WAIT: state_q <= S_GRAB;
        S_GRAB: begin
          if (idx_q == 2'd0) begin
            len_q <= ilen(i_pmem_data);
          end
          if (idx_q == 2'd0 ? ilen(i_pmem_data) == 2'd1 : idx_q + 2'd1 == len_q) begin
            state_q <= S_EXEC;
            idx_q   <= 2'd0;
          end else begin
            state_q <= S_WAIT;
            idx_q   <= idx_q + 2'd1;
          end
        end
        S_EXEC: begin
          state_q <= (op_q == `BCME_OP_LONG_CALL) ? S_PUSH_LO : S_WAIT;
          done_q  <= (op_q != `BCME_OP_LONG_CALL);
        end
        S_PUSH_LO: state_q <= S_PUSH_HI;
        S_PUSH_HI: begin
          state_q <= S_WAIT;
          done_q  <= 1'b1;
        end
        default: state_q <= S_WAIT;
      endcase
    end
  end

  // Instruction byte capture
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      op_q <= `BCME_RST_BYTE;
      b1_q <= `BCME_RST_BYTE;
      b2_q <= `BCME_RST_BYTE;
    end else if (state_q == S_GRAB) begin
      case (idx_q)
        2'd0:    op_q <= i_pmem_data;
        2'd1:    b1_q <= i_pmem_data;
        default: b2_q <= i_pmem_data;
      endcase
    end
  end

  // Program counter: step per byte, reload on branch
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pc_q <= `BCME_RST_PC;
    end else if (state_q == S_GRAB) begin
      pc_q <= pc_q + 16'h0001;
    end else if (exec && (op_q == `BCME_OP_LONG_JUMP)) begin
      pc_q <= {b1_q, b2_q};
    end else if (exec && take) begin
      pc_q <= br_tgt;
    end else if (state_q == S_PUSH_HI) begin
      pc_q <= {b1_q, b2_q};
    end
  end

  // Stack pointer: pre-increment before each push write
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sp_q <= `BCME_RST_SP;
    end else if (state_q == S_PUSH_LO || state_q == S_PUSH_HI) begin
      sp_q <= sp_q + 8'h01;
    end else if (wr.en && !wr.raw && wr.addr == `BCME_SFR_SP) begin
      sp_q <= wr.data;
    end
  end

  // Internal RAM: pushes and moves; return address is pc+3 already
  always_ff @(posedge i_clk) begin
    if (state_q == S_PUSH_LO) begin
      ram[sp_q + 8'h01] <= pc_q[7:0];
    end else if (state_q == S_PUSH_HI) begin
      ram[sp_q + 8'h01] <= pc_q[15:8];
    end else if (wr.en && (wr.raw || !wr.addr[7])) begin
      ram[wr.addr] <= wr.data;
    end
  end

  // Registers reachable by direct writes only; branches never touch them
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      acc_q   <= `BCME_RST_BYTE;
      b_q     <= `BCME_RST_BYTE;
      psw_q   <= `BCME_RST_BYTE;
      dpl_q   <= `BCME_RST_BYTE;
      dph_q   <= `BCME_RST_BYTE;
      latch_q <= {4{`BCME_RST_LATCH}};
    end else if (wr.en && !wr.raw) begin
      case (wr.addr)
        `BCME_SFR_ACC: acc_q      <= wr.data;
        `BCME_SFR_B:   b_q        <= wr.data;
        `BCME_SFR_PSW: psw_q      <= wr.data;
        `BCME_SFR_DPL: dpl_q      <= wr.data;
        `BCME_SFR_DPH: dph_q      <= wr.data;
        `BCME_SFR_P0:  latch_q.p0 <= wr.data;
        `BCME_SFR_P1:  latch_q.p1 <= wr.data;
        `BCME_SFR_P2:  latch_q.p2 <= wr.data;
        `BCME_SFR_P3:  latch_q.p3 <= wr.data;
        default: ;                                  // RAM, SP or unmapped
      endcase
    end
  end

  // Outputs straight from flops
  assign o_pmem_addr  = pc_q;
  assign o_port_latch = latch_q;
  assign o_acc        = acc_q;
  assign o_sp         = sp_q;
  assign o_data_pointer = {dph_q, dpl_q};
  assign o_psw        = psw_q;
  assign o_instr_done = done_q;

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  a_ind_jump_tgt: assert property (
    exec && is_ind |=> pc_q == $past({dph_q, dpl_q}) + {8'h00, $past(acc_q)})
    else $error("indirect jump target wrong");
  a_ind_jump_keep: assert property (
    exec && is_ind |=> $stable(acc_q) && $stable(dpl_q) && $stable(dph_q) && $stable(psw_q))
    else $error("indirect jump changed state");
  a_bit_clr_take: assert property (
    exec && op_q == `BCME_OP_JBIT_CLR && !bit_val
      |=> pc_q == $past(pc_q) + {{8{$past(b2_q[7])}}, $past(b2_q)})
    else $error("bit-clear branch target wrong");
  a_cy_set_stay: assert property (
    exec && op_q == `BCME_OP_JCY_CLR && psw_q[`BCME_PSW_CY] |=> $stable(pc_q) && $stable(psw_q))
    else $error("carry-clear branch taken with carry set");
  a_acc_nz_take: assert property (
    exec && op_q == `BCME_OP_JACC_NZ && acc_q != 8'h00
      |=> pc_q == $past(pc_q) + {{8{$past(b1_q[7])}}, $past(b1_q)})
    else $error("nonzero branch not taken");
  a_acc_z_stay: assert property (
    exec && op_q == `BCME_OP_JACC_Z && acc_q != 8'h00 |=> $stable(pc_q) && $stable(acc_q))
    else $error("zero branch taken on nonzero");
  a_call_push: assert property (
    exec && op_q == `BCME_OP_LONG_CALL
      |-> ##2 (ram[sp_q] == pc_q[7:0]) ##1 (sp_q == 8'($past(sp_q, 3) + 8'h02)
      && ram[sp_q] == $past(pc_q[15:8], 1) && pc_q == {b1_q, b2_q} && o_instr_done))
    else $error("long call push or target wrong");
  a_long_jump: assert property (
    exec && op_q == `BCME_OP_LONG_JUMP |=> pc_q == $past({b1_q, b2_q}) && $stable(sp_q))
    else $error("long jump wrong");
  a_move_flags: assert property (
    wr.en && wr.addr != `BCME_SFR_PSW |=> $stable(psw_q))
    else $error("move changed flags");

  c_ind_jump: cover property (exec && is_ind && acc_q != 8'h00);
  c_long_call: cover property (state_q == S_PUSH_HI);
  c_bit_taken: cover property (exec && op_q == `BCME_OP_JBIT_CLR && !bit_val);
  c_dir_dir: cover property (exec && op_q == `BCME_OP_MV_DIR_DIR);

endmodule : bcme_core
`default_nettype wire

// *** verif/bcme_pmem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module bcme_pmem_model (
  // Clock
  input  wire logic        i_clk,
  // Fetch address and returned byte
  input  wire logic [15:0] i_addr,
  output logic [7:0]       o_data
);
  // Program image, written directly by the bench between runs
  logic [7:0] mem [0:65535];

  // Byte shows one cycle after its address, as the core expects;
  // a slow memory is not modelled since the core has no wait input
  always_ff @(posedge i_clk) begin
    o_data <= mem[i_addr];
  end
endmodule : bcme_pmem_model
`default_nettype wire

// *** verif/branch_call_move_exec_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module branch_call_move_exec_test;
  import bcme_pkg::*;

  // Stimulus and observed signals
  logic        i_clk     = 1'b0;
  logic        i_sys_rst = 1'b1;
  bcme_port_t  port_pins = '0;
  bcme_port_t  port_latch;
  logic [15:0] pmem_addr;
  logic [7:0]  pmem_data;
  logic [7:0]  acc;
  logic [7:0]  sp;
  logic [15:0] data_pointer;
  logic [7:0]  psw;
  logic        done;
  int          mismatches = 0;
  int          compares   = 0;

  // 40 MHz clock
  always #12.5 i_clk = ~i_clk;

  bcme_core uut (
    .i_clk        (i_clk),
    .i_sys_rst    (i_sys_rst),
    .o_pmem_addr  (pmem_addr),
    .i_pmem_data  (pmem_data),
    .i_port_pins  (port_pins),
    .o_port_latch (port_latch),
    .o_acc        (acc),
    .o_sp         (sp),
    .o_data_pointer (data_pointer),
    .o_psw        (psw),
    .o_instr_done (done)
  );

  bcme_pmem_model pm (
    .i_clk  (i_clk),
    .i_addr (pmem_addr),
    .o_data (pmem_data)
  );

  // One comparison, reported at once on mismatch
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error: %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Blank image: 00 decodes as a one-byte no-op
  task automatic clr();
    for (int a = 0; a < 65536; a++) pm.mem[a] = 8'h00;
  endtask : clr

  // Place a byte sequence in program memory
  task automatic prog(input logic [15:0] a, input logic [7:0] q[$]);
    foreach (q[i]) pm.mem[a + 16'(i)] = q[i];
  endtask : prog

  // Short reset so each scenario fetches from address zero
  task automatic restart();
    @(negedge i_clk);
    i_sys_rst = 1'b1;
    repeat (2) @(negedge i_clk);
    i_sys_rst = 1'b0;
  endtask : restart

  // Wait for n retired instructions, bounded so a stuck core is caught
  task automatic run(input int n);
    int seen;
    int cyc;
    seen = 0;
    cyc = 0;
    while (seen < n && cyc < 200 * n) begin
      @(negedge i_clk);
      cyc++;
      if (done === 1'b1) seen++;
    end
    if (seen < n) begin
      mismatches++;
      $display("Error: retired count expected %0d seen %0d", n, seen);
    end
  endtask : run

  // Pointer near the top so the sum wraps and carries out of the low byte
  task automatic t_indirect();
    clr();
    prog(16'h0000, {8'h74, 8'h20, 8'h75, 8'h82, 8'hF0, 8'h75, 8'h83, 8'hFF, 8'h73});
    restart();
    run(4);
    check("indirect target", 16'h0010, pmem_addr);
    check("indirect acc", 16'h0020, {8'h00, acc});
    check("indirect pointer", 16'hFFF0, data_pointer);
    check("indirect psw", 16'h0000, {8'h00, psw});
    $display("test indirect jump done");
  endtask : t_indirect

  // Conditional branch sitting at address 5, next instruction at 7
  task automatic t_branch(input logic [7:0] op, input logic [7:0] a, input logic [7:0] st,
                          input logic [7:0] rel, input logic taken);
    logic [7:0]  psw_before;
    logic [15:0] exp;
    clr();
    prog(16'h0000, {8'h74, a, 8'h75, 8'hD0, st, op, rel});
    restart();
    run(2);
    psw_before = psw;
    run(1);
    exp = taken ? 16'h0007 + {{8{rel[7]}}, rel} : 16'h0007;
    check("branch next fetch", exp, pmem_addr);
    check("branch acc", {8'h00, a}, {8'h00, acc});
    check("branch psw", {8'h00, psw_before}, {8'h00, psw});
    $display("test branch %h done", op);
  endtask : t_branch

  // Bit test on a port reads the latch; a byte read reads the pins
  task automatic t_bit_clear();
    clr();
    prog(16'h0000, {8'h30, 8'h90, 8'h20, 8'h75, 8'h90, 8'hFE, 8'h30, 8'h90, 8'h40});
    // Then a bit in the RAM bit area: bit 0F is bit 7 of byte 21
    prog(16'h0049, {8'hE5, 8'hA0, 8'h75, 8'h21, 8'h7F, 8'h30, 8'h0F, 8'h10});
    port_pins = '{p3: 8'h00, p2: 8'h5A, p1: 8'h00, p0: 8'h00};
    restart();
    run(1);
    check("bit set not taken", 16'h0003, pmem_addr);
    port_pins.p1 = 8'hFF;
    run(2);
    check("bit clear taken", 16'h0049, pmem_addr);
    check("bit latch kept", 16'h00FE, {8'h00, port_latch.p1});
    run(1);
    check("byte read of pins", 16'h005A, {8'h00, acc});
    run(2);
    check("ram bit clear taken", 16'h0061, pmem_addr);
    $display("test bit clear done");
  endtask : t_bit_clear

  // Target near the top of the space, nothing pushed
  task automatic t_long_jump();
    clr();
    prog(16'h0000, {8'h02, 8'hFF, 8'hFE});
    restart();
    run(1);
    check("long jump target", 16'hFFFE, pmem_addr);
    check("long jump sp", 16'h0007, {8'h00, sp});
    check("long jump psw", 16'h0000, {8'h00, psw});
    $display("test long jump done");
  endtask : t_long_jump

  // Call from 1234, return address read back from the stack
  task automatic t_long_call();
    clr();
    prog(16'h0000, {8'h75, 8'h81, 8'h30, 8'h02, 8'h12, 8'h34});
    prog(16'h1234, {8'h12, 8'hAB, 8'hCD});
    prog(16'hABCD, {8'h78, 8'h31, 8'hE6, 8'h78, 8'h32, 8'hE6});
    restart();
    run(3);
    check("call target", 16'hABCD, pmem_addr);
    check("call sp", 16'h0032, {8'h00, sp});
    check("call psw", 16'h0000, {8'h00, psw});
    run(2);
    check("stack low byte", 16'h0037, {8'h00, acc});
    run(2);
    check("stack high byte", 16'h0012, {8'h00, acc});
    $display("test long call done");
  endtask : t_long_call

  // Several source and destination modes, source left intact
  task automatic t_move();
    clr();
    prog(16'h0000, {8'h74, 8'h3C, 8'hF5, 8'h40, 8'h85, 8'h40, 8'hA0, 8'h74, 8'h00,
                     8'hE5, 8'h40, 8'h78, 8'h50, 8'hF6, 8'hE8, 8'hE6});
    restart();
    run(5);
    check("move to port latch", 16'h003C, {8'h00, port_latch.p2});
    check("move source kept", 16'h003C, {8'h00, acc});
    run(3);
    check("move reg to acc", 16'h0050, {8'h00, acc});
    run(1);
    check("move indirect", 16'h003C, {8'h00, acc});
    check("move psw", 16'h0000, {8'h00, psw});
    $display("test byte move done");
  endtask : t_move

  // Bank one selected; register, indirect and upper-RAM forms of the move
  task automatic t_move_modes();
    clr();
    prog(16'h0000, {8'h75, 8'hD0, 8'h08, 8'h74, 8'hA5, 8'hF9, 8'h89, 8'h60, 8'h78, 8'h70,
                    8'h76, 8'hC3, 8'h86, 8'hA0, 8'hA7, 8'h70, 8'hAA, 8'h60, 8'h74, 8'h00,
                    8'hE7, 8'hEA});
    restart();
    run(11);
    check("move indirect to latch", 16'h00C3, {8'h00, port_latch.p2});
    check("move upper ram via pointer", 16'h00C3, {8'h00, acc});
    check("move bank psw", 16'h0008, {8'h00, psw});
    run(1);
    check("move bank register", 16'h00A5, {8'h00, acc});
    $display("test move modes done");
  endtask : t_move_modes

  // Single exit for normal end and watchdog
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  // Main sequence
  initial begin
    repeat (10) @(negedge i_clk);
    i_sys_rst = 1'b0;
    t_indirect();
    t_branch(8'h60, 8'h00, 8'h00, 8'hF9, 1'b1);
    t_branch(8'h60, 8'h01, 8'h00, 8'hF9, 1'b0);
    t_branch(8'h70, 8'h01, 8'h00, 8'h80, 1'b1);
    t_branch(8'h70, 8'h00, 8'h00, 8'h10, 1'b0);
    t_branch(8'h50, 8'h00, 8'h00, 8'h05, 1'b1);
    t_branch(8'h50, 8'h00, 8'h80, 8'h05, 1'b0);
    t_bit_clear();
    t_long_jump();
    t_long_call();
    t_move();
    t_move_modes();
    report_and_stop();
  end

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #2000000;
    mismatches++;
    $display("Error: watchdog expected finish seen hang");
    report_and_stop();
  end
endmodule : branch_call_move_exec_test
`default_nettype wire
